/* File: core/adcc_ctrl.sv */
// adcc_ctrl: register bank, prescaler and conversion sequencer of the 10-bit converter
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps

// Overview of operation
// RQ1 - channel code 1000 routes and powers temperature sensor
// RQ2 - software uses internal reference, single conversions
// RQ3 - bits 7:6 select reference source
// RQ4 - reference change deferred until conversion completes
// RQ5 - bit 5 left-adjusts result, applied immediately
// RQ6 - mux register bit 4 reads zero
// RQ7 - bits 3:0 select channel, change deferred
// RQ8 - enable powers converter; clearing aborts conversion
// RQ9 - start bit starts conversion; free-running restarts
// RQ10 - first conversion 25 cycles, later 13
// RQ11 - start reads one while busy; zero ignored
// RQ12 - auto-trigger starts on selected source rising edge
// RQ13 - done flag set when result updated
// RQ14 - flag cleared by vector or writing one
// RQ15 - interrupt while flag, enable, global enable
// RQ16 - divider codes give divide by 2..128
// RQ17 - right adjust layout of result bytes
// RQ18 - left adjust layout of result bytes
// RQ19 - low byte read locks result until high read
// RQ20 - trigger code zero is free-running, no trigger
// RQ21 - divider and starts only while enabled
module adcc_ctrl
	import adcc_pkg::*;
(
	input  wire logic            sys_clk_i,		// 250 MHz system clock
	input  wire logic            srst_i,		// synchronous reset, active high
	input  wire logic [8:0]      avs_address_i,	// byte address
	input  wire logic            avs_read_i,
	input  wire logic            avs_write_i,
	input  wire logic [31:0]     avs_writedata_i,
	input  wire logic [3:0]      avs_byteenable_i,
	output logic      [31:0]     avs_readdata_o,
	output logic                 avs_waitrequest_o,
	input  wire logic [9:0]      conversion_result_i,	// from analog core, valid at done
	input  wire logic [7:0]      trigger_sources_i,	// trigger flags, bit 0 unused
	input  wire logic            global_irq_enable_i,
	input  wire logic            irq_vector_ack_i,	// vector executed, one pulse
	output adcc_core_ctl_t       core_ctl_o,
	output logic                 irq_req_o
);

	// ----------------------------------------------------------------------
	// state
	// ----------------------------------------------------------------------
	logic             wait_ff;	// waitrequest flop
	logic [31:0]      rdata_ff;	// read data flop
	logic [1:0]       ref_ff;	// written reference_select
	logic             lar_ff;	// left_adjust_result
	logic [3:0]       ch_ff;	// written input_channel_select
	logic [1:0]       ref_app_ff;	// reference in use by the core
	logic [3:0]       ch_app_ff;	// channel in use by the core
	logic             en_ff;	// converter_enable
	logic             busy_ff;	// conversion_start as read
	logic             ate_ff;	// auto_trigger_enable
	logic             flag_ff;	// conversion_done_flag
	logic             ie_ff;	// done_irq_enable
	logic [2:0]       div_ff;	// clock_divider_select
	logic [2:0]       ts_ff;	// trigger_source_select
	logic [9:0]       data_ff;	// latched conversion_result
	logic             lock_ff;	// result update blocked
	logic             first_ff;	// next conversion initialises
	logic             trig_prev_ff;	// trigger level last cycle
	logic [6:0]       pre_ff;	// prescaler count
	logic [4:0]       cnt_ff;	// converter cycles in this conversion
	logic [4:0]       len_ff;	// length of this conversion
	adcc_state_t      state_ff;
	adcc_core_ctl_t   core_ff;
	logic             irq_ff;

	// ----------------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------------
	// divide mask: tick when the masked prescaler bits are all one
	function automatic logic [6:0] div_mask(input logic [2:0] sel);
		logic [6:0] m;
		m = 7'h01;
		case (sel)
			3'd0, 3'd1: m = 7'h01;	// divide by 2
			3'd2:       m = 7'h03;
			3'd3:       m = 7'h07;
			3'd4:       m = 7'h0F;
			3'd5:       m = 7'h1F;
			3'd6:       m = 7'h3F;
			3'd7:       m = 7'h7F;	// divide by 128
			default:    m = 7'h01;
		endcase
		return m;
	endfunction : div_mask

	// word-aligned register hit on lane 0
	function automatic logic reg_hit(input logic [8:0] a, input logic [6:0] idx);
		return (a[8:2] == idx) && (a[1:0] == 2'b00);
	endfunction : reg_hit

	// ----------------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------------
	logic       acc;		// request taken at this edge
	logic       wr_acc;		// lane-0 write taken
	logic [7:0] wd;			// write byte
	logic       wr_ctrl;
	logic       wr_mux;
	logic       wr_trig;
	logic       rd_low;
	logic       rd_high;
	logic       rd_mux;		// mux register read answered

	assign acc     = (avs_read_i | avs_write_i) & ~wait_ff;
	assign rd_mux  = acc & avs_read_i & reg_hit(avs_address_i, ADCC_IDX_MUX);
	assign wr_acc  = acc & avs_write_i & avs_byteenable_i[0];
	assign wd      = avs_writedata_i[7:0];
	assign wr_ctrl = wr_acc & reg_hit(avs_address_i, ADCC_IDX_CTRL);
	assign wr_mux  = wr_acc & reg_hit(avs_address_i, ADCC_IDX_MUX);
	assign wr_trig = wr_acc & reg_hit(avs_address_i, ADCC_IDX_TRIG);
	assign rd_low  = acc & avs_read_i & reg_hit(avs_address_i, ADCC_IDX_RES_LOW);
	assign rd_high = acc & avs_read_i & reg_hit(avs_address_i, ADCC_IDX_RES_HIGH);

	// ----------------------------------------------------------------------
	// sequencer decode
	// ----------------------------------------------------------------------
	logic       nxt_en;		// enable after this edge
	logic       adc_tick;		// converter clock enable
	logic       done;		// conversion completes at this edge
	logic       trig_lvl;		// selected trigger level
	logic       go;			// conversion begins at this edge
	logic [7:0] low_rd;
	logic [7:0] high_rd;
	logic [7:0] ctrl_rd;
	logic [7:0] mux_rd;

	assign nxt_en   = wr_ctrl ? wd[ADCC_CTRL_EN] : en_ff;
	// prescaler only runs while enabled
	assign adc_tick = en_ff && ((pre_ff & div_mask(div_ff)) == div_mask(div_ff));	// RQ16 RQ21
	assign done     = (state_ff == ADCC_CONV) && adc_tick && (cnt_ff == len_ff - 5'd1);	// RQ10
	// free-running has no trigger level of its own, so switching to it fires nothing
	assign trig_lvl = (ts_ff != ADCC_TS_FREE) && trigger_sources_i[ts_ff];	// RQ20

	// starts need the converter on; a busy converter ignores further starts
	always_comb
	begin
		go = 1'b0;
		if (nxt_en && ((state_ff == ADCC_IDLE) || done))	// RQ21
		begin
			if (wr_ctrl && wd[ADCC_CTRL_START])
				go = 1'b1;	// RQ9
			else if (ate_ff && trig_lvl && !trig_prev_ff)
				go = 1'b1;	// RQ12
			else if (done && ate_ff && (ts_ff == ADCC_TS_FREE))
				go = 1'b1;	// RQ9 RQ20
		end
	end

	// presentation follows the adjust bit at once, even mid-conversion
	assign low_rd  = lar_ff ? {data_ff[1:0], 6'h00} : data_ff[7:0];	// RQ5 RQ17 RQ18
	assign high_rd = lar_ff ? data_ff[9:2] : {6'h00, data_ff[9:8]};	// RQ5 RQ17 RQ18
	assign ctrl_rd = {en_ff, busy_ff, ate_ff, flag_ff, ie_ff, div_ff};	// RQ11
	assign mux_rd  = {ref_ff, lar_ff, 1'b0, ch_ff};	// RQ6

	// ----------------------------------------------------------------------
	// Avalon slave: one wait state, then the answer
	// ----------------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			wait_ff <= 1'b1;
		else if ((avs_read_i | avs_write_i) && wait_ff)
			wait_ff <= 1'b0;	// answer next edge
		else
			wait_ff <= 1'b1;
	end

	// read data prepared during the wait state; unmapped reads return zero
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			rdata_ff <= 32'h0000_0000;
		else if (avs_read_i && wait_ff)
		begin
			if (reg_hit(avs_address_i, ADCC_IDX_RES_LOW))
				rdata_ff <= {24'h00_0000, low_rd};
			else if (reg_hit(avs_address_i, ADCC_IDX_RES_HIGH))
				rdata_ff <= {24'h00_0000, high_rd};
			else if (reg_hit(avs_address_i, ADCC_IDX_CTRL))
				rdata_ff <= {24'h00_0000, ctrl_rd};
			else if (reg_hit(avs_address_i, ADCC_IDX_TRIG))
				rdata_ff <= {29'h0000_0000, ts_ff};
			else if (reg_hit(avs_address_i, ADCC_IDX_MUX))
				rdata_ff <= {24'h00_0000, mux_rd};
			else
				rdata_ff <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			ref_ff <= ADCC_RST_BYTE[7:6];
			lar_ff <= 1'b0;
			ch_ff  <= ADCC_RST_BYTE[3:0];
		end
		else if (wr_mux)
		begin
			ref_ff <= wd[ADCC_MUX_REF_HI:ADCC_MUX_REF_LO];	// RQ3
			lar_ff <= wd[ADCC_MUX_LAR];	// RQ5
			ch_ff  <= wd[ADCC_MUX_CH_HI:0];	// RQ7
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			en_ff  <= 1'b0;
			ate_ff <= 1'b0;
			ie_ff  <= 1'b0;
			div_ff <= ADCC_RST_BYTE[2:0];
		end
		else if (wr_ctrl)
		begin
			en_ff  <= wd[ADCC_CTRL_EN];	// RQ8
			ate_ff <= wd[ADCC_CTRL_ATE];
			ie_ff  <= wd[ADCC_CTRL_IE];
			div_ff <= wd[ADCC_CTRL_DIV_HI:0];
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			ts_ff <= ADCC_TS_FREE;
		else if (wr_trig)
			ts_ff <= wd[ADCC_TRIG_TS_HI:0];
	end

	// ----------------------------------------------------------------------
	// prescaler: held at zero while off so the first tick is a full period
	// ----------------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i || !en_ff)
			pre_ff <= ADCC_PRE_RST;	// RQ21
		else
			pre_ff <= pre_ff + 7'd1;	// RQ16
	end

	// ----------------------------------------------------------------------
	// conversion sequencer
	// ----------------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			state_ff <= ADCC_IDLE;
			busy_ff  <= 1'b0;
			cnt_ff   <= 5'd0;
			len_ff   <= ADCC_NORMAL_CYC;
		end
		else if (!nxt_en)
		begin
			// switching off aborts whatever runs
			state_ff <= ADCC_IDLE;	// RQ8
			busy_ff  <= 1'b0;
			cnt_ff   <= 5'd0;
		end
		else if (go)
		begin
			state_ff <= ADCC_CONV;
			busy_ff  <= 1'b1;	// RQ11
			cnt_ff   <= 5'd0;
			// first start after enable, or together with it, initialises
			len_ff   <= (first_ff || !en_ff) ? ADCC_FIRST_CYC : ADCC_NORMAL_CYC;	// RQ10
		end
		else if (done)
		begin
			state_ff <= ADCC_IDLE;
			busy_ff  <= 1'b0;	// RQ11
		end
		else
		begin
			case (state_ff)
				ADCC_CONV:
				begin
					if (adc_tick)
						cnt_ff <= cnt_ff + 5'd1;
				end
				default:
					cnt_ff <= 5'd0;
			endcase
		end
	end

	// armed while the converter is off, used up by the first start
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			first_ff <= 1'b1;
		else if (!nxt_en)
			first_ff <= 1'b1;
		else if (go)
			first_ff <= 1'b0;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			trig_prev_ff <= 1'b0;
		else
			trig_prev_ff <= trig_lvl;
	end

	// ----------------------------------------------------------------------
	// result latch and read lock
	// ----------------------------------------------------------------------
	// a result arriving while locked is lost, keeping the pair consistent
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			data_ff <= ADCC_RST_RES;
		else if (done && !lock_ff && !rd_low)
			data_ff <= conversion_result_i;	// RQ19
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			lock_ff <= 1'b0;
		else if (rd_low)
			lock_ff <= 1'b1;	// RQ19
		else if (rd_high)
			lock_ff <= 1'b0;	// RQ19
	end

	// flag: completion wins over a clear in the same cycle
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			flag_ff <= 1'b0;
		else
			flag_ff <= done | (flag_ff & ~((wr_ctrl & wd[ADCC_CTRL_FLAG]) | irq_vector_ack_i));	// RQ13 RQ14
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			irq_ff <= 1'b0;
		else
			irq_ff <= flag_ff & ie_ff & global_irq_enable_i;	// RQ15
	end

	// ----------------------------------------------------------------------
	// core control: selections move only between conversions
	// ----------------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			ref_app_ff <= ADCC_RST_BYTE[7:6];
			ch_app_ff  <= ADCC_RST_BYTE[3:0];
		end
		else if ((state_ff == ADCC_IDLE) || done)
		begin
			ref_app_ff <= ref_ff;	// RQ4
			ch_app_ff  <= ch_ff;	// RQ7
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			core_ff <= '0;
		else
		begin
			core_ff.power_on  <= en_ff;	// RQ8
			// the sensor follows the channel code alone, powered or not
			core_ff.sensor_on <= (ch_app_ff == ADCC_CH_TEMP);	// RQ1
			core_ff.start     <= go;
			core_ff.adc_tick  <= adc_tick;
			core_ff.ref_sel   <= ref_app_ff;	// RQ3
			core_ff.channel   <= ch_app_ff;	// RQ7
		end
	end

	assign avs_readdata_o    = rdata_ff;
	assign avs_waitrequest_o = wait_ff;
	assign core_ctl_o        = core_ff;
	assign irq_req_o         = irq_ff;

	// cycles since the last start; lets a cover see long conversions without a wide delay range
	logic [11:0] conv_age_ff;
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i || go)
			conv_age_ff <= 12'h000;
		else if (conv_age_ff != 12'hFFF)
			conv_age_ff <= conv_age_ff + 12'h001;
	end

	// ----------------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	off_no_conv_a: assert property (!en_ff |-> state_ff == ADCC_IDLE && !busy_ff)	// RQ8
		else $error("conversion runs while disabled");
	busy_reads_a: assert property (ctrl_rd[ADCC_CTRL_START] == (state_ff == ADCC_CONV))	// RQ11
		else $error("start bit does not show busy");
	mux_bit4_zero_a: assert property (rd_mux |-> avs_readdata_o[4] == 1'b0)	// RQ6
		else $error("mux bit 4 not zero");
	right_layout_a: assert property (rd_high && !lar_ff |-> avs_readdata_o[7:2] == 6'h00)	// RQ17
		else $error("right adjust layout wrong");
	left_layout_a: assert property (rd_low && lar_ff |-> avs_readdata_o[5:0] == 6'h00)	// RQ18
		else $error("left adjust layout wrong");
	conv_length_a: assert property (done |-> len_ff == ADCC_FIRST_CYC || len_ff == ADCC_NORMAL_CYC)	// RQ10
		else $error("bad conversion length");
	first_long_a: assert property (go && first_ff |=> len_ff == ADCC_FIRST_CYC)	// RQ10
		else $error("first conversion not 25 cycles");
	flag_sets_a: assert property (done |=> flag_ff)	// RQ13
		else $error("flag not set at completion");
	irq_follow_a: assert property (flag_ff && ie_ff && global_irq_enable_i |=> irq_req_o)	// RQ15
		else $error("interrupt request missing");
	lock_hold_a: assert property (lock_ff && !rd_high |=> $stable(data_ff))	// RQ19
		else $error("result changed while locked");
	ref_defer_a: assert property (state_ff == ADCC_CONV && !done |=> $stable(ref_app_ff))	// RQ4
		else $error("reference changed mid conversion");
	sensor_on_a: assert property (en_ff && ch_app_ff == ADCC_CH_TEMP |=> core_ctl_o.sensor_on)	// RQ1
		else $error("sensor not enabled");
	div2_tick_a: assert property (en_ff && div_ff == 3'd1 && $stable(div_ff) && adc_tick |=> !adc_tick)	// RQ16
		else $error("divide by two ticks too fast");

	conv_done_c: cover property (done && conv_age_ff <= 12'hC80);
	free_run_c:  cover property (done && go && ate_ff);
	lock_drop_c: cover property (done && lock_ff);

endmodule : adcc_ctrl

/* File: core/adcc_pkg.sv */
// adcc_pkg: register map, field layout, timing counts and carrier types of the converter control
package adcc_pkg;

	// ----------------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------------
	localparam logic [6:0] ADCC_IDX_RES_LOW  = 7'h78;	// result_low_byte
	localparam logic [6:0] ADCC_IDX_RES_HIGH = 7'h79;	// result_high_byte
	localparam logic [6:0] ADCC_IDX_CTRL     = 7'h7A;	// converter_control_status
	localparam logic [6:0] ADCC_IDX_TRIG     = 7'h7B;	// trigger source register
	localparam logic [6:0] ADCC_IDX_MUX      = 7'h7C;	// input_mux_select

	// ----------------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------------
	localparam int ADCC_MUX_REF_HI  = 7;	// reference_select [7:6]
	localparam int ADCC_MUX_REF_LO  = 6;
	localparam int ADCC_MUX_LAR     = 5;	// left_adjust_result
	localparam int ADCC_MUX_CH_HI   = 3;	// input_channel_select [3:0]
	localparam int ADCC_CTRL_EN     = 7;	// converter_enable
	localparam int ADCC_CTRL_START  = 6;	// conversion_start
	localparam int ADCC_CTRL_ATE    = 5;	// auto_trigger_enable
	localparam int ADCC_CTRL_FLAG   = 4;	// conversion_done_flag
	localparam int ADCC_CTRL_IE     = 3;	// done_irq_enable
	localparam int ADCC_CTRL_DIV_HI = 2;	// clock_divider_select [2:0]
	localparam int ADCC_TRIG_TS_HI  = 2;	// trigger_source_select [2:0]

	// ----------------------------------------------------------------------
	// reset values and encodings
	// ----------------------------------------------------------------------
	localparam logic [7:0] ADCC_RST_BYTE  = 8'h00;
	localparam logic [9:0] ADCC_RST_RES   = 10'h000;
	localparam logic [3:0] ADCC_CH_TEMP   = 4'h8;	// temperature_channel
	localparam logic [3:0] ADCC_CH_BGAP   = 4'hE;	// bandgap
	localparam logic [3:0] ADCC_CH_GND    = 4'hF;	// ground
	localparam logic [1:0] ADCC_REF_EXT   = 2'h0;	// external_reference_pin
	localparam logic [1:0] ADCC_REF_AVCC  = 2'h1;
	localparam logic [1:0] ADCC_REF_INT   = 2'h3;
	localparam logic [2:0] ADCC_TS_FREE   = 3'h0;	// free-running
	localparam logic [6:0] ADCC_PRE_RST   = 7'h00;

	// ----------------------------------------------------------------------
	// conversion lengths in converter clock cycles
	// ----------------------------------------------------------------------
	localparam logic [4:0] ADCC_FIRST_CYC  = 5'd25;
	localparam logic [4:0] ADCC_NORMAL_CYC = 5'd13;

	// ----------------------------------------------------------------------
	// types
	// ----------------------------------------------------------------------
	typedef enum logic {ADCC_IDLE, ADCC_CONV} adcc_state_t;

	// control bundle toward the analog core
	typedef struct packed {
		logic       power_on;	// converter powered
		logic       sensor_on;	// temperature sensor powered
		logic       start;	// one-cycle pulse: sample and begin
		logic       adc_tick;	// one-cycle converter clock enable
		logic [1:0] ref_sel;	// applied reference_select
		logic [3:0] channel;	// applied input_channel_select
	} adcc_core_ctl_t;

endpackage : adcc_pkg

/* File: sim/adcc_core_model.sv */
// adcc_core_model: behavioural analog core that answers the converter control
`timescale 1ns/100ps
module adcc_core_model
	import adcc_pkg::*;
(
	input  wire logic           sys_clk_i,	// system clock
	input  wire logic           srst_i,	// synchronous reset, active high
	input  wire adcc_core_ctl_t core_ctl_i,	// controls from the block
	input  wire logic [9:0]     value_i,	// level the bench wants converted
	output logic      [9:0]     result_o,	// result toward the block
	output logic      [7:0]     ticks_o	// converter clocks since last start
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [9:0] last_ff;	// last level shown while powered
	logic [7:0] ticks_ff;	// tick count, cleared by each start pulse

	// count converter clocks so a first conversion can be told from later ones
	always_ff @(posedge sys_clk_i)
		if (srst_i || core_ctl_i.start)
			ticks_ff <= 8'h00;
		else if (core_ctl_i.adc_tick)
			ticks_ff <= ticks_ff + 8'h01;

	// remember the last driven level for the released state
	always_ff @(posedge sys_clk_i)
		if (srst_i)
			last_ff <= 10'h155;
		else if (core_ctl_i.power_on)
			last_ff <= result_o;

	// unpowered core shows the inverse, so a stale value never passes for a fresh one
	always_comb
		result_o = core_ctl_i.power_on ? value_i : ~last_ff;

	assign ticks_o = ticks_ff;
endmodule : adcc_core_model

/* File: sim/tb_top.sv */
// tb_top: self-checking bench of the converter control with its analog core model
`timescale 1ns/100ps
module tb_top
	import adcc_pkg::*;
();
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic           sys_clk_i, srst_i, avs_read_i, avs_write_i, gie, ack;
	logic [8:0]     avs_address_i;	// byte address
	logic [31:0]    avs_writedata_i, avs_readdata_o;
	logic [3:0]     avs_byteenable_i;	// only lane 0 carries registers
	logic           avs_waitrequest_o, irq;
	logic [9:0]     val, res;	// level to convert, core result
	logic [7:0]     trig, ticks, rq;	// triggers, tick count, last read byte
	adcc_core_ctl_t ctl;
	int             bad_count, tests_run, starts, cycles;

	adcc_ctrl i_adcc_ctrl (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .conversion_result_i(res),
		.trigger_sources_i(trig), .global_irq_enable_i(gie),
		.irq_vector_ack_i(ack), .core_ctl_o(ctl), .irq_req_o(irq));

	adcc_core_model i_adcc_core_model (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
		.core_ctl_i(ctl), .value_i(val), .result_o(res), .ticks_o(ticks));

	// ----------------------------------------------------------------
	// clock, start pulse count and hang guard
	// ----------------------------------------------------------------
	initial
	begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	// the guard sits well above the longest run of slow-divider conversions
	always @(posedge sys_clk_i)
	begin
		cycles <= cycles + 1;
		if (ctl.start === 1'b1)
			starts <= starts + 1;
		if (cycles == 30000)
		begin
			bad_count++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task complete_run;
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// one bus cycle: request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [6:0] idx, input logic [7:0] d);
		@(posedge sys_clk_i);
		avs_address_i   <= {idx, 2'b00};
		avs_write_i     <= w;
		avs_read_i      <= ~w;
		avs_writedata_i <= {24'h00_0000, d};
		do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
		rq = avs_readdata_o[7:0];
		avs_write_i <= 1'b0;
		avs_read_i  <= 1'b0;
	endtask : bus

	task automatic rc(input string n, input logic [6:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk(n, {2'b00, e}, {2'b00, rq});
	endtask : rc

	// poll the status register until the done flag shows
	task wait_done;
		do bus(1'b0, ADCC_IDX_CTRL, 8'h00); while (rq[4] !== 1'b1);
	endtask : wait_done

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_regs;
		logic [6:0] idx [6] = '{ADCC_IDX_RES_LOW, ADCC_IDX_RES_HIGH, ADCC_IDX_CTRL,
			ADCC_IDX_TRIG, ADCC_IDX_MUX, 7'h10};
		foreach (idx[i]) rc("reset", idx[i], 8'h00);
		bus(1'b1, ADCC_IDX_MUX, 8'hFF);
		rc("mux", ADCC_IDX_MUX, 8'hEF);
		chk("chan", 10'h00F, {6'h00, ctl.channel});
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, ADCC_IDX_MUX, {i[1:0], 6'h08});
			rc("mux", ADCC_IDX_MUX, {i[1:0], 6'h08});
			chk("ref", 10'(i), {8'h00, ctl.ref_sel});
			chk("sensor", 10'h001, {9'h000, ctl.sensor_on});
		end
	endtask : t_regs

	// first and later conversion, both layouts, flag handling, result lock
	task t_result;
		val <= 10'h2D6;
		bus(1'b1, ADCC_IDX_MUX, 8'h01);
		bus(1'b1, ADCC_IDX_CTRL, 8'hC7);
		rc("busy", ADCC_IDX_CTRL, 8'hC7);
		wait_done;
		chk("ticks", 10'd25, {2'b00, ticks});
		rc("low", ADCC_IDX_RES_LOW, 8'hD6);
		rc("high", ADCC_IDX_RES_HIGH, 8'h02);
		bus(1'b1, ADCC_IDX_MUX, 8'h21);
		rc("low", ADCC_IDX_RES_LOW, 8'h80);
		rc("high", ADCC_IDX_RES_HIGH, 8'hB5);
		bus(1'b1, ADCC_IDX_CTRL, 8'h87);
		rc("flag", ADCC_IDX_CTRL, 8'h97);
		bus(1'b1, ADCC_IDX_CTRL, 8'h97);
		rc("clear", ADCC_IDX_CTRL, 8'h87);
		val <= 10'h155;
		bus(1'b1, ADCC_IDX_CTRL, 8'hC7);
		wait_done;
		chk("ticks", 10'd13, {2'b00, ticks});
		rc("low", ADCC_IDX_RES_LOW, 8'h40);
		val <= 10'h3FF;
		bus(1'b1, ADCC_IDX_CTRL, 8'hD7);
		bus(1'b1, ADCC_IDX_MUX, 8'hEE);
		rc("mux", ADCC_IDX_MUX, 8'hEE);
		chk("chan", 10'h001, {6'h00, ctl.channel});
		chk("ref", 10'h000, {8'h00, ctl.ref_sel});
		wait_done;
		rc("high", ADCC_IDX_RES_HIGH, 8'h55);
		chk("chan", 10'h00E, {6'h00, ctl.channel});
		chk("ref", 10'h003, {8'h00, ctl.ref_sel});
	endtask : t_result

	task t_irq;
		bus(1'b1, ADCC_IDX_MUX, 8'hC8);
		bus(1'b1, ADCC_IDX_CTRL, 8'hDB);
		wait_done;
		repeat (2) @(posedge sys_clk_i);
		chk("irq", 10'h000, {9'h000, irq});
		gie <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		chk("irq", 10'h001, {9'h000, irq});
		ack <= 1'b1;
		@(posedge sys_clk_i);
		ack <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		chk("irq", 10'h000, {9'h000, irq});
		rc("ack", ADCC_IDX_CTRL, 8'h8B);
	endtask : t_irq

	// abort by disabling, then a start refused while off
	task t_abort;
		int s;
		logic [7:0] t0;
		s = starts;
		bus(1'b1, ADCC_IDX_CTRL, 8'hC7);
		bus(1'b1, ADCC_IDX_CTRL, 8'h07);
		repeat (2) @(posedge sys_clk_i);
		chk("power", 10'h000, {9'h000, ctl.power_on});
		bus(1'b1, ADCC_IDX_CTRL, 8'h47);
		t0 = ticks;
		repeat (300) @(posedge sys_clk_i);
		chk("ticks", {2'b00, t0}, {2'b00, ticks});
		rc("off", ADCC_IDX_CTRL, 8'h07);
		chk("starts", 10'(s + 1), 10'(starts));
	endtask : t_abort

	task t_div;
		int n;
		for (int c = 0; c < 8; c++)
		begin
			bus(1'b1, ADCC_IDX_CTRL, 8'hD0 | 8'(c));
			// the next sample may still be a tick of the old divider
			@(posedge sys_clk_i);
			do @(posedge sys_clk_i); while (ctl.adc_tick !== 1'b1);
			n = 0;
			do
			begin
				@(posedge sys_clk_i);
				n++;
			end
			while (ctl.adc_tick !== 1'b1);
			chk("div", 10'(c < 2 ? 2 : 1 << c), 10'(n));
			wait_done;
		end
	endtask : t_div

	// edge trigger, free-running entry without event, free run, back to single
	task t_auto;
		int s;
		s = starts;
		bus(1'b1, ADCC_IDX_TRIG, 8'h02);
		bus(1'b1, ADCC_IDX_CTRL, 8'hB1);
		trig <= 8'h04;
		while (starts == s) @(posedge sys_clk_i);
		wait_done;
		chk("trig", 10'(s + 1), 10'(starts));
		bus(1'b1, ADCC_IDX_TRIG, 8'h00);
		repeat (40) @(posedge sys_clk_i);
		chk("free", 10'(s + 1), 10'(starts));
		bus(1'b1, ADCC_IDX_CTRL, 8'hE1);
		while (starts < s + 4) @(posedge sys_clk_i);
		bus(1'b1, ADCC_IDX_CTRL, 8'h91);
		repeat (60) @(posedge sys_clk_i);
		s = starts;
		repeat (100) @(posedge sys_clk_i);
		chk("single", 10'(s), 10'(starts));
		trig <= 8'h00;
	endtask : t_auto

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		srst_i = 1'b1;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 9'h000;
		avs_writedata_i = 32'h0000_0000;
		avs_byteenable_i = 4'h1;
		gie = 1'b0;
		ack = 1'b0;
		val = 10'h000;
		trig = 8'h00;
		repeat (3) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		t_regs;
		t_result;
		t_irq;
		t_abort;
		t_div;
		t_auto;
		complete_run;
	end
endmodule : tb_top
